// >>> logic/tpd_pkg.sv
// Summary of operation
// - status bits 31:6 and 4:2 read zero; bit 5 zero before version 3.5
// - from 3.5, status bit 5 mirrors os lock status bit 1
// - state-lost bit sets whenever core domain is powered down or reset
// - read while core down or in reset returns 1, bit unchanged
// - read while core up returns state-lost bit then clears it
// - memory-mapped read under software lock does not clear state-lost
// - state-lost bit has no influence on trace register access handling
// - status bit 0 reads 1 when trace registers are accessible
// - powered-up bit 0 means trace register accesses get error response
// - single power domain variant returns fixed 0x00000001
// - control bit 3 requests trace power; other control bits reserved
// - status register reached only via memory map or debugger
package tpd_pkg;
  localparam logic [1:0] TPD_SEL_NONE    = 2'h0;
  localparam logic [1:0] TPD_SEL_STATUS  = 2'h1;
  localparam logic [1:0] TPD_SEL_CONTROL = 2'h2;
  localparam int         TPD_STS_UP      = 0;
  localparam int         TPD_STS_LOST    = 1;
  localparam int         TPD_STS_OSLOCK  = 5;
  localparam int         TPD_CTL_PWRREQ  = 3;
  localparam int         TPD_OSLSR_LOCK  = 1;
  localparam logic [31:0] TPD_SINGLE_VAL = 32'h0000_0001;
  localparam logic [31:0] TPD_ZERO       = 32'h0000_0000;
  localparam logic        TPD_LOST_RST   = 1'b1;
  localparam logic        TPD_PWRREQ_RST = 1'b0;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  sel;
    logic        mmap;
    logic [31:0] wdata;
  } tpd_req_type;

  typedef struct packed {
    logic        core_up;
    logic        trace_up;
    logic        sw_locked;
    logic [31:0] oslsr;
  } tpd_env_type;
endpackage

// >>> logic/tpd_sync.sv
`timescale 1ns/1ns
module tpd_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// >>> logic/tpd_top.sv
`timescale 1ns/1ns
module tpd_top #(
  parameter bit V35         = 1'b1,
  parameter bit SINGLE_DOM  = 1'b0
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire tpd_pkg::tpd_req_type req,
  input  wire logic                 trace_acc,
  input  wire logic                 core_pwr_up,
  input  wire logic                 core_in_reset,
  input  wire logic                 trace_pwr_up,
  input  wire logic                 sw_locked,
  input  wire logic [31:0]          os_lock_status_reg,
  output logic [31:0]               rdata,
  output logic                      rvalid,
  output logic                      trace_err,
  output logic                      trace_ok,
  output logic                      trace_pwr_req
);
  //////////////////////////////////////////////////////////////////////////
  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  logic [34:0] env_raw;
  logic [34:0] env_sync;
  tpd_pkg::tpd_env_type env;
  logic        core_ok;
  logic        lost_reg;
  logic        lost_next;
  logic [31:0] status_val;
  logic [31:0] rdata_next;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // power and lock inputs come from other domains
  assign env_raw = {core_pwr_up & ~core_in_reset, trace_pwr_up, sw_locked,
                    os_lock_status_reg};
  tpd_sync #(.W(35)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (env_raw),
    .q       (env_sync)
  );
  assign env     = env_sync;
  assign core_ok = env.core_up;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic is_sel(input tpd_pkg::tpd_req_type r,
                                  input logic [1:0] s);
    is_sel = (r.sel == s);
  endfunction

  always_comb begin
    lost_next = lost_reg;
    if (!core_ok) begin
      // set while down, read leaves it
      lost_next = 1'b1;
    end else if (req.rd && is_sel(req, tpd_pkg::TPD_SEL_STATUS)
                 && !(req.mmap && env.sw_locked)) begin
      // clear on read unless locked mmap
      lost_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lost_reg <= tpd_pkg::TPD_LOST_RST;
    end else begin
      lost_reg <= lost_next;
    end
  end

  always_comb begin
    status_val = tpd_pkg::TPD_ZERO;
    status_val[tpd_pkg::TPD_STS_UP]   = env.trace_up;
    // read in down state shows 1
    status_val[tpd_pkg::TPD_STS_LOST] = lost_reg | ~core_ok;
    status_val[tpd_pkg::TPD_STS_OSLOCK] =
      V35 & env.oslsr[tpd_pkg::TPD_OSLSR_LOCK];
    if (SINGLE_DOM) begin
      status_val = tpd_pkg::TPD_SINGLE_VAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power request bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_pwr_req <= tpd_pkg::TPD_PWRREQ_RST;
    end else if (req.wr && is_sel(req, tpd_pkg::TPD_SEL_CONTROL)) begin
      trace_pwr_req <= req.wdata[tpd_pkg::TPD_CTL_PWRREQ];
    end
  end

  always_comb begin
    rdata_next = tpd_pkg::TPD_ZERO;
    if (is_sel(req, tpd_pkg::TPD_SEL_STATUS)) begin
      rdata_next = status_val;
    end else if (is_sel(req, tpd_pkg::TPD_SEL_CONTROL)) begin
      rdata_next[tpd_pkg::TPD_CTL_PWRREQ] = trace_pwr_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata  <= tpd_pkg::TPD_ZERO;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      rdata  <= req.rd ? rdata_next : tpd_pkg::TPD_ZERO;
    end
  end

  // error depends on power bit only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_err <= 1'b0;
      trace_ok  <= 1'b0;
    end else begin
      trace_err <= trace_acc & ~status_val[tpd_pkg::TPD_STS_UP];
      trace_ok  <= trace_acc & status_val[tpd_pkg::TPD_STS_UP];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence s_status_read;
    req.rd && req.sel == tpd_pkg::TPD_SEL_STATUS;
  endsequence

  sequence s_status_write;
    req.wr && req.sel == tpd_pkg::TPD_SEL_STATUS;
  endsequence

  sequence s_control_read;
    req.rd && req.sel == tpd_pkg::TPD_SEL_CONTROL;
  endsequence

  sequence s_control_write;
    req.wr && req.sel == tpd_pkg::TPD_SEL_CONTROL;
  endsequence

  sequence s_none_read;
    req.rd && req.sel == tpd_pkg::TPD_SEL_NONE;
  endsequence

  a_lost_set_down: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !core_ok |=> lost_reg)
    else $error("state-lost not set while core down");

  a_lost_stays_set: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lost_reg && !req.rd |=> lost_reg)
    else $error("state-lost cleared without a read");

  a_lost_no_spurious: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !lost_reg && core_ok |=> !lost_reg)
    else $error("state-lost set while core up");

  a_down_read_one: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and !core_ok and !SINGLE_DOM)
      |=> rvalid && rdata[1])
    else $error("down read did not return 1");

  a_down_read_keeps: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and !core_ok) |=> lost_reg)
    else $error("down read changed state-lost");

  a_read_clears: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and core_ok and !(req.mmap && env.sw_locked))
      |=> !lost_reg)
    else $error("state-lost not cleared by read");

  a_lost_read_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and core_ok and !SINGLE_DOM)
      |=> rdata[1] == $past(lost_reg))
    else $error("read did not return state-lost");

  a_lock_keeps: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and req.mmap and env.sw_locked and lost_reg)
      |=> lost_reg)
    else $error("locked read cleared state-lost");

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_status_read |=> rvalid && rdata[31:6] == 26'h0 && rdata[4:2] == 3'h0)
    else $error("reserved status bits nonzero");

  a_none_read_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_none_read |=> rvalid && rdata == tpd_pkg::TPD_ZERO)
    else $error("unselected read not zero");

  a_up_bit_shows: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and !SINGLE_DOM) |=> rdata[0] == $past(env.trace_up))
    else $error("powered-up bit wrong");

  a_oslock_mirror: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and !SINGLE_DOM)
      |=> rdata[5] == (V35 & $past(env.oslsr[tpd_pkg::TPD_OSLSR_LOCK])))
    else $error("os lock mirror wrong");

  a_single_fixed: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (s_status_read and SINGLE_DOM) |=> rdata == tpd_pkg::TPD_SINGLE_VAL)
    else $error("single domain status not fixed");

  a_read_answered: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    req.rd |=> rvalid)
    else $error("read not answered");

  a_idle_quiet: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !req.rd |=> !rvalid && rdata == tpd_pkg::TPD_ZERO)
    else $error("read data without a read");

  a_err_when_down: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trace_acc && !env.trace_up && !SINGLE_DOM |=> trace_err)
    else $error("no error for access while down");

  a_acc_one_answer: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trace_acc |=> trace_err != trace_ok)
    else $error("access answer not unique");

  a_no_acc_quiet: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !trace_acc |=> !trace_err && !trace_ok)
    else $error("access answer without access");

  a_err_ok_apart: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(trace_err && trace_ok))
    else $error("error and ok together");

  a_ok_ignores_lost: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    trace_acc && env.trace_up |=> trace_ok && !trace_err)
    else $error("access refused while powered");

  a_pwr_req_write: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_control_write
      |=> trace_pwr_req == $past(req.wdata[tpd_pkg::TPD_CTL_PWRREQ]))
    else $error("power request not taken");

  a_ctl_read_bit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_control_read |=> rdata[3] == $past(trace_pwr_req)
      && rdata[31:4] == 28'h0 && rdata[2:0] == 3'h0)
    else $error("control read bits wrong");

  a_status_wr_ignored: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_status_write |=> $stable(trace_pwr_req))
    else $error("status write moved power request");

  a_pwr_req_held: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(req.wr && req.sel == tpd_pkg::TPD_SEL_CONTROL)
      |=> $stable(trace_pwr_req))
    else $error("power request changed without write");
endmodule

// >>> verification/tpd_host_model.sv
`timescale 1ns/1ns
module tpd_host_model (
  input  wire logic            sys_clk,
  output tpd_pkg::tpd_req_type req,
  input  wire logic [31:0]     rdata,
  input  wire logic            rvalid
);
  logic [31:0] last;
  initial req = '0;
  task automatic acc(input logic w, input logic [1:0] s,
                     input logic mm, input logic [31:0] wd);
    int n;
    req = '{rd: !w, wr: w, sel: s, mmap: mm, wdata: wd};
    @(negedge sys_clk);
    // released data must not look valid
    req = '0;
    req.wdata = ~wd;
    n = 0;
    while (!w && rvalid !== 1'b1 && n < 3) begin
      @(negedge sys_clk);
      n++;
    end
    last = rdata;
  endtask
endmodule

// >>> verification/trace_power_down_status_ctrl_tb_top.sv
`timescale 1ns/1ns
module trace_power_down_status_ctrl_tb_top;
  logic sys_clk, rstn, trace_acc, core_pwr_up, core_in_reset;
  logic trace_pwr_up, sw_locked, rvalid, trace_err, trace_ok;
  logic trace_pwr_req, rv_s, pwr_s;
  logic [31:0] rd_s;
  logic [31:0] os_lock_status_reg, rdata;
  tpd_pkg::tpd_req_type req;
  int mismatches, total_checks, cycles;
  tpd_top #(.V35(1'b1), .SINGLE_DOM(1'b0)) dut (.sys_clk(sys_clk),
    .rstn(rstn), .req(req), .trace_acc(trace_acc),
    .core_pwr_up(core_pwr_up), .core_in_reset(core_in_reset),
    .trace_pwr_up(trace_pwr_up), .sw_locked(sw_locked),
    .os_lock_status_reg(os_lock_status_reg), .rdata(rdata),
    .rvalid(rvalid), .trace_err(trace_err), .trace_ok(trace_ok),
    .trace_pwr_req(trace_pwr_req));
  tpd_top #(.V35(1'b1), .SINGLE_DOM(1'b1)) dut_single (.sys_clk(sys_clk),
    .rstn(rstn), .req(req), .trace_acc(trace_acc),
    .core_pwr_up(core_pwr_up), .core_in_reset(core_in_reset),
    .trace_pwr_up(trace_pwr_up), .sw_locked(sw_locked),
    .os_lock_status_reg(os_lock_status_reg), .rdata(rd_s),
    .rvalid(rv_s), .trace_err(), .trace_ok(),
    .trace_pwr_req(pwr_s));
  tpd_host_model h (.sys_clk(sys_clk), .req(req), .rdata(rdata),
    .rvalid(rvalid));
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // sized well above the roughly 50 cycles of traffic
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] sv(input logic l, u, o);
    return {26'h0, o, 3'h0, l, u};
  endfunction
  task automatic sts(input logic mm, input logic [31:0] e);
    h.acc(1'b0, tpd_pkg::TPD_SEL_STATUS, mm, 32'h0000_0000);
    check("status", e, h.last);
    check("rvalid", 32'h0000_0001, rvalid);
    check("single_valid", 32'h0000_0001, rv_s);
    check("single_status", tpd_pkg::TPD_SINGLE_VAL, rd_s);
  endtask
  // inputs pass two sync flops, so let them settle
  task automatic env(input logic cu, cr, tu, lk, input logic [31:0] os);
    core_pwr_up = cu;
    core_in_reset = cr;
    trace_pwr_up = tu;
    sw_locked = lk;
    os_lock_status_reg = os;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic tacc(input logic e);
    trace_acc = 1'b1;
    @(negedge sys_clk);
    trace_acc = 1'b0;
    check("trace_err", e, trace_err);
    check("trace_ok", !e, trace_ok);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic sc_down();
    sts(1'b1, sv(1, 0, 0));
    sts(1'b1, sv(1, 0, 0));
    tacc(1'b1);
  endtask
  task automatic sc_up();
    env(1, 0, 1, 0, 32'h0000_0000);
    sts(1'b0, sv(1, 1, 0));
    sts(1'b0, sv(0, 1, 0));
    tacc(1'b0);
  endtask
  task automatic sc_lost_lock();
    env(1, 1, 1, 0, 32'h0000_0000);
    env(1, 0, 1, 1, 32'h0000_0000);
    tacc(1'b0);
    sts(1'b1, sv(1, 1, 0));
    sts(1'b1, sv(1, 1, 0));
    sts(1'b0, sv(1, 1, 0));
    sts(1'b0, sv(0, 1, 0));
  endtask
  task automatic sc_oslock();
    env(1, 0, 1, 0, 32'h0000_0002);
    sts(1'b0, sv(0, 1, 1));
    env(1, 0, 0, 0, 32'hffff_fffd);
    sts(1'b0, sv(0, 0, 0));
  endtask
  task automatic sc_ctl();
    h.acc(1'b1, tpd_pkg::TPD_SEL_CONTROL, 1'b1, 32'hffff_ffff);
    check("pwr_req", 1'b1, trace_pwr_req);
    check("pwr_single", 1'b1, pwr_s);
    h.acc(1'b1, tpd_pkg::TPD_SEL_STATUS, 1'b1, 32'hffff_ffff);
    h.acc(1'b0, tpd_pkg::TPD_SEL_CONTROL, 1'b0, 32'h0000_0000);
    check("control", 32'h0000_0008, h.last);
    check("pwr_hold", 1'b1, trace_pwr_req);
    sts(1'b1, sv(0, 0, 0));
    h.acc(1'b0, tpd_pkg::TPD_SEL_NONE, 1'b1, 32'h0000_0000);
    check("none", 32'h0000_0000, h.last);
    h.acc(1'b1, tpd_pkg::TPD_SEL_CONTROL, 1'b0, 32'hffff_fff7);
    check("pwr_req", 1'b0, trace_pwr_req);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    trace_acc = 1'b0;
    cycles = 0;
    void'(sv(0, 0, 0));
    env(0, 0, 0, 0, 32'h0000_0000);
    rstn = 1'b1;
    repeat (6) @(negedge sys_clk);
    sc_down();
    sc_up();
    sc_lost_lock();
    sc_oslock();
    sc_ctl();
    close_out();
  end
endmodule
